// ==== fsync_ctrl.sv ====
// Frame synchronizer control: settings, indicators, freeze and output path
//
// Summary of operation
// RULE1: Error light on while reference is absent.
// RULE2: Freeze light on while output from memory.
// RULE3: Standard mismatch reported to host, lights untouched.
// RULE4: Freeze inactive after reset by default.
// RULE5: Host toggles apply settings; up first option.
// RULE6: Lock source video forces plain delay mode; the block only drives LOCK_VIDEO_OUT, freeze and phase settings stay active.
// RULE7: Horizontal phase steps one clock per toggle.
// RULE8: Vertical phase steps one line per toggle.
// RULE9: Auto freeze holds last field on loss.
// RULE10: Manual freeze follows mode and field settings.
// RULE11: Freeze mode picks frame or field.
// RULE12: Field freeze repeats field one or two.
// RULE13: Frozen output is last field or black.
// RULE14: Phase offsets never exceed one frame.
`timescale 1ns/1ps

// ****************************************************
// Elastic buffer in the video path
// ****************************************************
module fsync_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    // Drain side
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    // Pointers carry one extra wrap bit
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_st_t;
    fifo_st_t st_q, st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty, push, pop;

    // Flags from pointer compare
    always_comb begin
        empty = st_q.wp == st_q.rp;
        full = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
        push = wr_valid_in && !full;
        pop = rd_ready_in && !empty;
        wr_ready_out = !full;
        rd_valid_out = !empty;
        rd_data_out = mem[st_q.rp[AW-1:0]];
        st_d = st_q;
        if (push) begin
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    // Pointer state
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[st_q.wp[AW-1:0]] <= wr_data_in;
        end
    end
endmodule

// ****************************************************
// Top: control of the synchronizer
// ****************************************************
module fsync_ctrl
    import fsync_pkg::*;
(
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // Switch and status pins
    input wire logic [SEL_W-1:0] FUNC_SEL_IN,
    input wire logic TOGGLE_UP_IN,
    input wire logic TOGGLE_DOWN_IN,
    input wire logic REF_PRESENT_IN,
    input wire logic VIDEO_LOST_IN,
    input wire logic MISMATCH_IN,
    // Video input from host
    input wire logic [DATA_W-1:0] VID_DATA_IN,
    input wire logic VID_VALID_IN,
    output logic VID_READY_OUT,
    // Frame memory read data
    input wire logic [DATA_W-1:0] MEM_DATA_IN,
    // Video output
    output logic [DATA_W-1:0] VID_DATA_OUT,
    output logic VID_VALID_OUT,
    input wire logic VID_READY_IN,
    // Indicators and host report
    output logic ERROR_LED_OUT,
    output logic FREEZE_LED_OUT,
    output logic MISMATCH_OUT,
    // Settings toward the memory controller
    output logic LOCK_VIDEO_OUT,
    output logic MEM_READ_OUT,
    output logic FIELD_ONLY_OUT,
    output logic FIELD2_OUT,
    output logic [H_W-1:0] H_PHASE_OUT,
    output logic [V_W-1:0] V_PHASE_OUT
);
    // All state of the block except the input buffer
    typedef struct packed {
        logic [SEL_W-1:0] sel_s1;
        logic [SEL_W-1:0] sel_s2;
        logic up_s1, up_s2, up_s3;
        logic dn_s1, dn_s2, dn_s3;
        logic ref_s1, ref_s2;
        logic lost_s1, lost_s2;
        logic mm_s1, mm_s2;
        logic lock_video, auto_frz, man_frz, field_mode, field2, black_sig;
        logic [H_W-1:0] h_ph;
        logic [V_W-1:0] v_ph;
        logic err, frz, mism;
        logic [DATA_W-1:0] vo_data;
        logic vo_valid;
        logic chroma;
    } ctrl_st_t;

    ctrl_st_t st_q, st_d;
    logic [DATA_W-1:0] ff_data; // Buffered word
    logic ff_valid; // Buffer holds a word
    logic ff_pop; // Output stage takes a word
    logic up_ev, dn_ev; // Toggle edges
    logic frz_now; // Freeze condition

    // Input buffer instance
    fsync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_data_in(VID_DATA_IN),
        .wr_valid_in(VID_VALID_IN),
        .wr_ready_out(VID_READY_OUT),
        .rd_data_out(ff_data),
        .rd_valid_out(ff_valid),
        .rd_ready_in(ff_pop)
    );

    // Next state
    always_comb begin
        st_d = st_q;
        // Pin synchronisers
        st_d.sel_s1 = FUNC_SEL_IN;
        st_d.sel_s2 = st_q.sel_s1;
        st_d.up_s1 = TOGGLE_UP_IN;
        st_d.up_s2 = st_q.up_s1;
        st_d.up_s3 = st_q.up_s2;
        st_d.dn_s1 = TOGGLE_DOWN_IN;
        st_d.dn_s2 = st_q.dn_s1;
        st_d.dn_s3 = st_q.dn_s2;
        st_d.ref_s1 = REF_PRESENT_IN;
        st_d.ref_s2 = st_q.ref_s1;
        st_d.lost_s1 = VIDEO_LOST_IN;
        st_d.lost_s2 = st_q.lost_s1;
        st_d.mm_s1 = MISMATCH_IN;
        st_d.mm_s2 = st_q.mm_s1;
        // RULE5: act on toggle edges only
        up_ev = st_q.up_s2 && !st_q.up_s3;
        dn_ev = st_q.dn_s2 && !st_q.dn_s3 && !up_ev;
        if (up_ev || dn_ev) begin
            case (st_q.sel_s2)
                // RULE6: up video, down reference
                SEL_LOCK: begin
                    st_d.lock_video = up_ev;
                end
                // RULE7: clock steps, RULE14 bounded
                SEL_HPH: begin
                    if (up_ev && st_q.h_ph < CLKS_PER_LINE - 11'h001) begin
                        st_d.h_ph = st_q.h_ph + 11'h001;
                    end else if (dn_ev && st_q.h_ph != 11'h000) begin
                        st_d.h_ph = st_q.h_ph - 11'h001;
                    end
                end
                // RULE8: line steps, RULE14 bounded
                SEL_VPH: begin
                    if (up_ev && st_q.v_ph < LINES_PER_FRAME - 10'h001) begin
                        st_d.v_ph = st_q.v_ph + 10'h001;
                    end else if (dn_ev && st_q.v_ph != 10'h000) begin
                        st_d.v_ph = st_q.v_ph - 10'h001;
                    end
                end
                // RULE9: up manual, down auto
                SEL_FRZ_AUTO: begin
                    st_d.auto_frz = dn_ev;
                end
                // RULE10: up off, down on
                SEL_FRZ_MAN: begin
                    st_d.man_frz = dn_ev;
                end
                // RULE11: up frame, down field
                SEL_FRZ_MODE: begin
                    st_d.field_mode = dn_ev;
                end
                // RULE12: up field 1, down field 2
                SEL_FRZ_FIELD: begin
                    st_d.field2 = dn_ev;
                end
                // RULE13: up last field, down black
                SEL_FRZ_SIG: begin
                    st_d.black_sig = dn_ev;
                end
                // Unused positions
                default: begin
                    st_d.lock_video = st_q.lock_video;
                end
            endcase
        end
        // RULE9: auto freeze on loss, RULE10 manual
        frz_now = st_q.man_frz || (st_q.auto_frz && st_q.lost_s2);
        // RULE2: freeze light tracks memory output
        st_d.frz = frz_now;
        // RULE1: error light on reference absence
        st_d.err = !st_q.ref_s2;
        // RULE3: mismatch goes only to host
        st_d.mism = st_q.mm_s2;
        // Output stage loads when empty or taken
        ff_pop = ff_valid && (!st_q.vo_valid || VID_READY_IN);
        if (ff_pop) begin
            st_d.vo_valid = 1'b1;
            st_d.chroma = !st_q.chroma;
            if (!st_q.frz) begin
                st_d.vo_data = ff_data;
            end else if (st_q.black_sig) begin
                // RULE13: black replaces frozen picture
                st_d.vo_data = st_q.chroma ? BLACK_C : BLACK_Y;
            end else begin
                st_d.vo_data = MEM_DATA_IN;
            end
        end else if (VID_READY_IN) begin
            st_d.vo_valid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q <= '0;
            // RULE4: freeze settings start inactive
            st_q.lock_video <= LOCK_VIDEO_RST;
            st_q.auto_frz <= AUTO_FRZ_RST;
            st_q.man_frz <= MAN_FRZ_RST;
            st_q.field_mode <= FIELD_MODE_RST;
            st_q.field2 <= FIELD2_RST;
            st_q.black_sig <= BLACK_SIG_RST;
            st_q.h_ph <= H_PHASE_RST;
            st_q.v_ph <= V_PHASE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from state
    assign VID_DATA_OUT = st_q.vo_data;
    assign VID_VALID_OUT = st_q.vo_valid;
    assign ERROR_LED_OUT = st_q.err;
    assign FREEZE_LED_OUT = st_q.frz;
    assign MEM_READ_OUT = st_q.frz;
    assign MISMATCH_OUT = st_q.mism;
    assign LOCK_VIDEO_OUT = st_q.lock_video;
    assign FIELD_ONLY_OUT = st_q.field_mode;
    assign FIELD2_OUT = st_q.field2;
    assign H_PHASE_OUT = st_q.h_ph;
    assign V_PHASE_OUT = st_q.v_ph;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    chk_error_light: assert property (!REF_PRESENT_IN |-> ##3 ERROR_LED_OUT) // RULE1
        else $error("error light missed absent reference");
    chk_freeze_light: assert property (ff_pop && !FREEZE_LED_OUT // RULE2
        |=> VID_DATA_OUT == $past(ff_data))
        else $error("live word not passed with freeze light off");
    chk_memory_out: assert property (ff_pop && FREEZE_LED_OUT && !st_q.black_sig // RULE13
        |=> VID_DATA_OUT == $past(MEM_DATA_IN))
        else $error("frozen word not read from memory");
    chk_mismatch_report: assert property (MISMATCH_IN |-> ##3 MISMATCH_OUT) // RULE3
        else $error("mismatch not reported");
    chk_freeze_idle: assert property (!st_q.man_frz && !st_q.auto_frz |=> !FREEZE_LED_OUT) // RULE4
        else $error("freeze without any freeze setting");
    chk_lock_video: assert property (up_ev && st_q.sel_s2 == SEL_LOCK |=> LOCK_VIDEO_OUT) // RULE6
        else $error("lock source not set to video");
    chk_h_step: assert property (up_ev && st_q.sel_s2 == SEL_HPH // RULE7
        && H_PHASE_OUT < CLKS_PER_LINE - 11'h001
        |=> H_PHASE_OUT == $past(H_PHASE_OUT) + 11'h001)
        else $error("horizontal phase step wrong");
    chk_v_step: assert property (dn_ev && st_q.sel_s2 == SEL_VPH // RULE8
        && V_PHASE_OUT != 10'h000
        |=> V_PHASE_OUT == $past(V_PHASE_OUT) - 10'h001)
        else $error("vertical phase step wrong");
    chk_auto_freeze: assert property (st_q.auto_frz && st_q.lost_s2 |=> FREEZE_LED_OUT) // RULE9
        else $error("auto freeze missed video loss");
    chk_phase_bound: assert property (H_PHASE_OUT < CLKS_PER_LINE // RULE14
        && V_PHASE_OUT < LINES_PER_FRAME)
        else $error("phase offset beyond one frame");

    cov_manual_freeze: cover property (dn_ev && st_q.sel_s2 == SEL_FRZ_MAN ##2 FREEZE_LED_OUT);
    cov_black_out: cover property (FREEZE_LED_OUT && st_q.black_sig && ff_pop);
    cov_h_wrap_stop: cover property (up_ev && H_PHASE_OUT == CLKS_PER_LINE - 11'h001);
endmodule

// ==== fsync_ctrl_tb_top.sv ====
// Self-checking bench for the frame synchronizer control block
`timescale 1ns/1ps

module fsync_ctrl_tb_top
    import fsync_pkg::*;
();

    // ****
    // Stimulus and observed signals
    // ****
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ref_ok = 1'b0;
    logic lost = 1'b0;
    logic mism = 1'b0;
    logic [DATA_W-1:0] mem = 10'h155;
    logic snk_rdy = 1'b0;
    logic run = 1'b0;
    logic [SEL_W-1:0] sel;
    logic up, dn, vin_v, vin_r, vo_v, err, frz, mis_o, lock, mrd, fonly, f2;
    logic [DATA_W-1:0] vin_d, vo_d, last_w, prev_w;
    logic [H_W-1:0] hph;
    logic [V_W-1:0] vph;
    logic chain = 1'b0; // Check word order
    logic first = 1'b1; // First word of a chain
    int miscompares = 0;
    int num_checks = 0;
    int taken = 0; // Words drained in a chain

    fsync_host_model i_fsync_host_model (.clk_in(mclk), .func_sel_out(sel), .up_out(up),
        .down_out(dn), .run_in(run), .data_out(vin_d), .valid_out(vin_v), .ready_in(vin_r));

    fsync_ctrl i_fsync_ctrl (.MCLK_IN(mclk), .RST_IN(rst), .FUNC_SEL_IN(sel),
        .TOGGLE_UP_IN(up), .TOGGLE_DOWN_IN(dn), .REF_PRESENT_IN(ref_ok),
        .VIDEO_LOST_IN(lost), .MISMATCH_IN(mism), .VID_DATA_IN(vin_d),
        .VID_VALID_IN(vin_v), .VID_READY_OUT(vin_r), .MEM_DATA_IN(mem),
        .VID_DATA_OUT(vo_d), .VID_VALID_OUT(vo_v), .VID_READY_IN(snk_rdy),
        .ERROR_LED_OUT(err), .FREEZE_LED_OUT(frz), .MISMATCH_OUT(mis_o),
        .LOCK_VIDEO_OUT(lock), .MEM_READ_OUT(mrd), .FIELD_ONLY_OUT(fonly),
        .FIELD2_OUT(f2), .H_PHASE_OUT(hph), .V_PHASE_OUT(vph));

    // Clock, 25 ns period
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic act(input logic [SEL_W-1:0] p, input logic u);
        i_fsync_host_model.actuate(p, u);
    endtask

    // Output words taken by the sink, seen mid-cycle
    always @(negedge mclk) begin
        if (vo_v === 1'b1 && snk_rdy === 1'b1) begin
            if (chain && !first) begin
                chk("word order", 16'(vo_d), 16'(last_w + 10'h001));
            end
            if (chain) begin
                taken++;
            end
            first = 1'b0;
            prev_w = last_w;
            last_w = vo_d;
        end
    end

    // Defaults, indicators and host report
    task automatic t_status();
        chk("freeze led", 16'(frz), 16'h0);
        chk("hphase", 16'(hph), 16'(H_PHASE_RST));
        chk("error led", 16'(err), 16'h1);
        ref_ok <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("error led", 16'(err), 16'h0);
        mism <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("mismatch", 16'(mis_o), 16'h1);
        chk("leds", 16'({err, frz}), 16'h0);
        mism <= 1'b0;
    endtask

    // Lock source and phase limits
    task automatic t_settings();
        act(SEL_LOCK, 1'b1);
        chk("lock", 16'(lock), 16'h1);
        act(SEL_LOCK, 1'b0);
        chk("lock", 16'(lock), 16'h0);
        act(SEL_HPH, 1'b0);
        chk("hphase", 16'(hph), 16'h0);
        act(SEL_HPH, 1'b1);
        act(SEL_HPH, 1'b1);
        chk("hphase", 16'(hph), 16'h2);
        act(SEL_HPH, 1'b0);
        chk("hphase", 16'(hph), 16'h1);
        act(SEL_VPH, 1'b0);
        chk("vphase", 16'(vph), 16'h0);
        act(SEL_VPH, 1'b1);
        chk("vphase", 16'(vph), 16'h1);
        act(4'h1, 1'b1);
        chk("unused pos", 16'({lock, hph}), 16'h1);
    endtask

    // Manual freeze, mode, field and signal
    task automatic t_freeze();
        run <= 1'b1;
        snk_rdy <= 1'b1;
        act(SEL_FRZ_MAN, 1'b0);
        chk("freeze", 16'({frz, mrd}), 16'h3);
        repeat (8) @(posedge mclk);
        chk("held word", 16'(last_w), 16'h155);
        act(SEL_FRZ_MODE, 1'b0);
        chk("field only", 16'(fonly), 16'h1);
        act(SEL_FRZ_FIELD, 1'b0);
        chk("field two", 16'(f2), 16'h1);
        act(SEL_FRZ_SIG, 1'b0);
        chk("black pair", 16'({prev_w, last_w} == {BLACK_Y, BLACK_C}
            || {prev_w, last_w} == {BLACK_C, BLACK_Y}), 16'h1);
        act(SEL_FRZ_SIG, 1'b1);
        act(SEL_FRZ_MAN, 1'b1);
        chk("freeze", 16'({frz, mrd}), 16'h0);
        run <= 1'b0;
    endtask

    // Automatic freeze on loss of input
    task automatic t_auto();
        lost <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("manual default", 16'(frz), 16'h0);
        act(SEL_FRZ_AUTO, 1'b0);
        chk("auto freeze", 16'(frz), 16'h1);
        lost <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("auto freeze", 16'(frz), 16'h0);
    endtask

    // Reset in mid-run restores every default
    task automatic t_reset();
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("defaults", 16'({lock, fonly, f2, frz}), 16'h0);
        chk("hphase", 16'(hph), 16'(H_PHASE_RST));
        chk("vphase", 16'(vph), 16'(V_PHASE_RST));
        chk("error led", 16'(err), 16'h1);
    endtask

    // Buffer filled against a stalled sink, then drained
    task automatic t_fifo();
        int n;
        snk_rdy <= 1'b0;
        run <= 1'b1;
        n = 0;
        while (vin_r !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk("buffer full", 16'(vin_r), 16'h0);
        chain = 1'b1;
        first = 1'b1;
        taken = 0;
        run <= 1'b0;
        snk_rdy <= 1'b1;
        repeat (60) @(posedge mclk);
        chk("buffer empty", 16'({vin_r, vo_v}), 16'h2);
        // Stage word, 32 buffered words and the one held at the source
        chk("words drained", 16'(taken), 16'h22);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_status();
        t_settings();
        t_freeze();
        t_auto();
        t_reset();
        t_fifo();
        end_sim();
    end
endmodule

// ==== fsync_host_model.sv ====
// Host converter model: switch actuations and video word source
`timescale 1ns/1ps

// ****
// Host side model
// ****
module fsync_host_model
    import fsync_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Switches
    output logic [SEL_W-1:0] func_sel_out,
    output logic up_out,
    output logic down_out,
    // Video source
    input wire logic run_in,
    output logic [DATA_W-1:0] data_out,
    output logic valid_out,
    input wire logic ready_in
);
    logic [DATA_W-1:0] word_q = 10'h000; // Next word to send
    logic rdy_s = 1'b0; // Ready as seen before the edge

    // Idle on an unused switch position
    initial begin
        func_sel_out = 4'h1;
        up_out = 1'b0;
        down_out = 1'b0;
        valid_out = 1'b0;
        data_out = 10'h3ff;
    end

    task automatic actuate(input logic [SEL_W-1:0] pos, input logic dir_up);
        @(posedge clk_in);
        func_sel_out <= pos;
        repeat (3) @(posedge clk_in);
        up_out <= dir_up;
        down_out <= !dir_up;
        repeat (3) @(posedge clk_in);
        up_out <= 1'b0;
        down_out <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    // Ready settles from registers, so take it mid-cycle
    always @(negedge clk_in) begin
        rdy_s = ready_in;
    end

    // Word held until taken; idle data toggles
    always @(posedge clk_in) begin
        if (valid_out && !rdy_s) begin
            valid_out <= 1'b1;
        end else if (run_in) begin
            valid_out <= 1'b1;
            data_out <= word_q;
            word_q <= word_q + 10'h001;
        end else begin
            valid_out <= 1'b0;
            data_out <= ~data_out;
        end
    end
endmodule

// ==== fsync_pkg.sv ====
// Shared constants for the frame synchronizer control block
package fsync_pkg;
    // Data path sizes
    localparam int DATA_W = 10;
    localparam int FIFO_DEPTH = 32;
    localparam int SEL_W = 4;
    localparam int H_W = 11;
    localparam int V_W = 10;
    // Function selector positions
    localparam logic [3:0] SEL_LOCK = 4'h0;
    localparam logic [3:0] SEL_HPH = 4'h2;
    localparam logic [3:0] SEL_VPH = 4'h3;
    localparam logic [3:0] SEL_FRZ_AUTO = 4'h4;
    localparam logic [3:0] SEL_FRZ_MAN = 4'h5;
    localparam logic [3:0] SEL_FRZ_MODE = 4'h6;
    localparam logic [3:0] SEL_FRZ_FIELD = 4'h7;
    localparam logic [3:0] SEL_FRZ_SIG = 4'h8;
    // Phase limits, one frame of delay at most
    localparam logic [10:0] CLKS_PER_LINE = 11'h6b4;
    localparam logic [9:0] LINES_PER_FRAME = 10'h20d;
    // Black level words for luma and chroma samples
    localparam logic [9:0] BLACK_Y = 10'h040;
    localparam logic [9:0] BLACK_C = 10'h200;
    // Reset values of the settings
    localparam logic LOCK_VIDEO_RST = 1'h0;
    localparam logic AUTO_FRZ_RST = 1'h0;
    localparam logic MAN_FRZ_RST = 1'h0;
    localparam logic FIELD_MODE_RST = 1'h0;
    localparam logic FIELD2_RST = 1'h0;
    localparam logic BLACK_SIG_RST = 1'h0;
    localparam logic [10:0] H_PHASE_RST = 11'h000;
    localparam logic [9:0] V_PHASE_RST = 10'h000;
endpackage
